// file: pkg/lpdpd_consts.svh
`ifndef LPDPD_CONSTS_SVH
`define LPDPD_CONSTS_SVH
// ca bit positions within the 4-bit command field
`define LPDPD_CA0_POS 0
`define LPDPD_CA1_POS 1
`define LPDPD_CA2_POS 2
// ca3 decodes mrw versus mrr inside the mode register group
`define LPDPD_CA3_POS 3
// reset value of the impedance code and of the trim code after zq reset
`define LPDPD_IMP_DEFAULT 4'h8
// timer for a calibration in flight, counted in link clock edges
`define LPDPD_ZQ_CAL_CYCLES 8'h20
// stable link clock rises needed before power-down exit is honoured
`define LPDPD_EXIT_STABLE_EDGES 2'h2
// depth of the zq trim history kept by the memory
`define LPDPD_TRIM_DEPTH 4
`endif

// file: pkg/lpdpd_pkg.sv
package lpdpd_pkg;
  typedef enum logic [3:0] {
    LPDPD_ACTIVE = 4'h1,
    LPDPD_PD     = 4'h2,
    LPDPD_DPD    = 4'h4,
    LPDPD_ZQCAL  = 4'h8
  } lpdpd_state_t;
endpackage

// file: src/lpdpd_power_ctrl.sv
`timescale 1ns/1ns
`include "lpdpd_consts.svh"
// Behaviour
// - with zq strapped to supply, ignore calibration commands, keep default impedance
// - cke low with cs_n high at ck rise enters power-down
// - in power-down only ck and cke buffers stay enabled
// - no internal refresh while in power-down
// - cke low, cs_n low, ca0 high, ca1 high, ca2 low enters deep power-down
// - deep power-down loses array, disables buffers except cke, and core power
// - nop is cs_n high, or cs_n low with ca0..ca2 all high
module lpdpd_power_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ck,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic [3:0] ca,
  input  wire logic       zq_tied_high,
  input  wire logic       zq_cmd,
  output logic            pd_q,
  output logic            dpd_q,
  output logic            in_buf_en_q,
  output logic            out_buf_en_q,
  output logic            core_pwr_en_q,
  output logic            refresh_en_q,
  output logic            array_valid_q,
  output logic            need_init_q,
  output logic            zq_busy_q,
  output logic      [3:0] imp_code_q,
  output logic      [3:0] trim_hist_q
);
  // two-flop synchronisers for every pin
  logic [8:0] s1_q;
  logic [8:0] s2_q;
  logic       ck_prev_q;
  lpdpd_pkg::lpdpd_state_t state_q;
  logic [7:0] zq_cnt_q;
  logic [1:0] stable_q;
  logic [1:0] hist_wr_q;
  logic       cke_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
    end else begin
      s1_q <= {zq_cmd, zq_tied_high, ca, cs_n, cke, ck};
      s2_q <= s1_q;
    end
  end

  wire       ck_s   = s2_q[0];
  wire       cke_s  = s2_q[1];
  wire       csn_s  = s2_q[2];
  wire [3:0] ca_s   = s2_q[6:3];
  wire       zqt_s  = s2_q[7];
  wire       zqc_s  = s2_q[8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_s;
    end
  end

  wire ck_rise = ck_s & ~ck_prev_q;

  function automatic logic lpdpd_is_nop(input logic csn, input logic [3:0] c);
    lpdpd_is_nop = csn | (c[`LPDPD_CA0_POS] & c[`LPDPD_CA1_POS] & c[`LPDPD_CA2_POS]);
  endfunction

  function automatic logic lpdpd_is_dpd(input logic csn, input logic [3:0] c);
    lpdpd_is_dpd = ~csn & c[`LPDPD_CA0_POS] & c[`LPDPD_CA1_POS] & ~c[`LPDPD_CA2_POS];
  endfunction

  // cke sampled on the previous ck rise, so entry needs a high-to-low step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_q <= 1'b1;
    end else if (ck_rise) begin
      cke_prev_q <= cke_s;
    end
  end

  wire enter_pd  = ck_rise & cke_prev_q & ~cke_s & csn_s;
  wire enter_dpd = ck_rise & cke_prev_q & ~cke_s & lpdpd_is_dpd(csn_s, ca_s);
  wire exit_pd   = ck_rise & cke_s & csn_s & (stable_q == `LPDPD_EXIT_STABLE_EDGES);
  // zq requests count on any cke-high edge, nop or not; strapped zq ignores them
  wire zq_start  = ck_rise & cke_s & zqc_s & ~zqt_s;
  // calibration ends on the last counted ck rise, so it spans the full count
  wire cal_end   = ck_rise & (zq_cnt_q == 8'h01);
  wire cal_done  = (state_q == lpdpd_pkg::LPDPD_ZQCAL) & cal_end & ~zqt_s;

  // count ck rises while in power-down; a stopped clock gives none
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_q <= 2'h0;
    end else if (state_q != lpdpd_pkg::LPDPD_PD) begin
      stable_q <= 2'h0;
    end else if (ck_rise && stable_q != `LPDPD_EXIT_STABLE_EDGES) begin
      stable_q <= stable_q + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= lpdpd_pkg::LPDPD_ACTIVE;
    end else begin
      case (state_q)
        lpdpd_pkg::LPDPD_ACTIVE: begin
          if (enter_dpd) begin
            state_q <= lpdpd_pkg::LPDPD_DPD;
          end else if (enter_pd) begin
            state_q <= lpdpd_pkg::LPDPD_PD;
          end else if (zq_start) begin
            state_q <= lpdpd_pkg::LPDPD_ZQCAL;
          end
        end
        lpdpd_pkg::LPDPD_PD: begin
          if (exit_pd) begin
            state_q <= lpdpd_pkg::LPDPD_ACTIVE;
          end
        end
        lpdpd_pkg::LPDPD_DPD: begin
          // waking from deep power-down leaves the die needing initialization
          if (ck_rise && cke_s) begin
            state_q <= lpdpd_pkg::LPDPD_ACTIVE;
          end
        end
        lpdpd_pkg::LPDPD_ZQCAL: begin
          if (cal_end) begin
            state_q <= lpdpd_pkg::LPDPD_ACTIVE;
          end
        end
        default: state_q <= lpdpd_pkg::LPDPD_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zq_cnt_q <= 8'h00;
    end else if (zq_start && state_q == lpdpd_pkg::LPDPD_ACTIVE) begin
      zq_cnt_q <= `LPDPD_ZQ_CAL_CYCLES;
    end else if (ck_rise && zq_cnt_q != 8'h00) begin
      zq_cnt_q <= zq_cnt_q - 8'h01;
    end
  end

  wire in_pd  = (state_q == lpdpd_pkg::LPDPD_PD);
  wire in_dpd = (state_q == lpdpd_pkg::LPDPD_DPD);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_q          <= 1'b0;
      dpd_q         <= 1'b0;
      in_buf_en_q   <= 1'b1;
      out_buf_en_q  <= 1'b1;
      core_pwr_en_q <= 1'b1;
      refresh_en_q  <= 1'b1;
      zq_busy_q     <= 1'b0;
    end else begin
      pd_q          <= in_pd;
      dpd_q         <= in_dpd;
      in_buf_en_q   <= ~(in_pd | in_dpd);
      out_buf_en_q  <= ~(in_pd | in_dpd);
      core_pwr_en_q <= ~in_dpd;
      refresh_en_q  <= ~(in_pd | in_dpd);
      zq_busy_q     <= (state_q == lpdpd_pkg::LPDPD_ZQCAL);
    end
  end

  // array is gone once deep power-down is reached; restored only by rst_n
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      array_valid_q <= 1'b1;
      need_init_q   <= 1'b0;
    end else if (in_dpd) begin
      array_valid_q <= 1'b0;
      need_init_q   <= 1'b1;
    end
  end

  // strapped zq keeps the default code; otherwise a finished calibration trims it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      imp_code_q <= `LPDPD_IMP_DEFAULT;
      hist_wr_q  <= 2'h0;
    end else if (zqt_s) begin
      imp_code_q <= `LPDPD_IMP_DEFAULT;
    end else if (cal_done) begin
      imp_code_q <= imp_code_q ^ ca_s;
      hist_wr_q  <= hist_wr_q + 2'h1;
    end
  end

  lpdpd_trim_mem u_trim (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (cal_done),
    .wr_addr   (hist_wr_q),
    .wr_data   (imp_code_q ^ ca_s),
    .rd_addr   (hist_wr_q - 2'h1),
    .rd_data_q (trim_hist_q)
  );

  a_pd_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == lpdpd_pkg::LPDPD_ACTIVE && enter_pd && !enter_dpd)
      |=> state_q == lpdpd_pkg::LPDPD_PD)
    else $error("power-down not entered");
  a_dpd_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == lpdpd_pkg::LPDPD_ACTIVE && enter_dpd) |=> ##1 dpd_q)
    else $error("deep power-down not entered");
  a_pd_buffers: assert property (@(posedge clk) disable iff (!rst_n)
    in_pd |=> !in_buf_en_q && !out_buf_en_q)
    else $error("buffers on in power-down");
  a_pd_norefresh: assert property (@(posedge clk) disable iff (!rst_n)
    (pd_q || dpd_q) |-> !refresh_en_q)
    else $error("refresh during power-down");
  a_pd_exit_cond: assert property (@(posedge clk) disable iff (!rst_n)
    (in_pd ##1 state_q == lpdpd_pkg::LPDPD_ACTIVE) |-> $past(csn_s) && $past(cke_s))
    else $error("exit without cs_n and cke high");
  a_exit_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (in_pd && exit_pd) |-> stable_q == 2'h2)
    else $error("exit before two clocks");
  a_dpd_array: assert property (@(posedge clk) disable iff (!rst_n)
    in_dpd |=> !array_valid_q && !core_pwr_en_q)
    else $error("array survived deep power-down");
  a_zq_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    zqt_s |=> imp_code_q == `LPDPD_IMP_DEFAULT && state_q != lpdpd_pkg::LPDPD_ZQCAL)
    else $error("calibration with strapped zq");
  a_nop_decode: assert property (@(posedge clk) disable iff (!rst_n)
    lpdpd_is_nop(csn_s, ca_s) |-> !lpdpd_is_dpd(csn_s, ca_s))
    else $error("nop decoded as deep power-down");

  c_pd_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    in_pd ##1 state_q == lpdpd_pkg::LPDPD_ACTIVE);
  c_dpd: cover property (@(posedge clk) disable iff (!rst_n) in_dpd);
  c_zq_done: cover property (@(posedge clk) disable iff (!rst_n) cal_done);
endmodule

// file: src/lpdpd_trim_mem.sv
`timescale 1ns/1ns
`include "lpdpd_consts.svh"
// small history of calibration results; read data registered
module lpdpd_trim_mem (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [3:0] wr_data,
  input  wire logic [1:0] rd_addr,
  output logic      [3:0] rd_data_q
);
  logic [3:0] mem_q [`LPDPD_TRIM_DEPTH];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `LPDPD_TRIM_DEPTH; i++) begin
        mem_q[i] <= `LPDPD_IMP_DEFAULT;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= `LPDPD_IMP_DEFAULT;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end
endmodule

// file: tb/lpdpd_ctrl_model.sv
`timescale 1ns/1ns
// memory controller side; ck runs free at 125 ns, pins move on clk falls while ck is low
module lpdpd_ctrl_model (
  input  wire logic       clk,
  output logic            ck,
  output logic            cke,
  output logic            cs_n,
  output logic      [3:0] ca,
  output logic            zq_cmd
);
  logic ck_run;

  // no read, write or mode commands are ever issued, so their cke timing holds
  initial begin
    ck_run = 1'b1;
    cke = 1'b1;
    cs_n = 1'b1;
    ca = 4'h7;
    zq_cmd = 1'b0;
  end

  // link clock; a cleared run flag parks ck low, which is how the clock is stopped
  initial begin
    ck = 1'b0;
    forever begin
      #63;
      ck = ck_run;
      #62;
      ck = 1'b0;
    end
  end

  // one ck rise per call; pins change while ck is low so they stand at the rise
  task automatic frame(input logic e, input logic cs, input logic [3:0] c, input logic z);
    wait (!ck);
    @(negedge clk);
    cke = e;
    cs_n = cs;
    ca = c;
    zq_cmd = z;
    @(posedge ck);
    @(negedge ck);
  endtask

  // stop the link clock for n clk periods; only used with cke low after two clocks
  task automatic stall(input int n);
    @(negedge clk);
    ck_run = 1'b0;
    repeat (n) @(negedge clk);
    ck_run = 1'b1;
  endtask

  // nop frames keep cke steady: after entry, through calibration, before exit
  task automatic nop(input logic e, input int n);
    repeat (n) frame(e, 1'b1, 4'h7, 1'b0);
  endtask

  // exit with cs_n high, then hold cke high and wait before any real command
  task automatic wake();
    frame(1'b1, 1'b1, 4'h7, 1'b0);
    nop(1'b1, 2);
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       clk;
  logic       rst_n;
  logic       zq_tied_high;
  logic       ck;
  logic       cke;
  logic       cs_n;
  logic [3:0] ca;
  logic       zq_cmd;
  logic       pd_q;
  logic       dpd_q;
  logic       in_buf_en_q;
  logic       out_buf_en_q;
  logic       core_pwr_en_q;
  logic       refresh_en_q;
  logic       array_valid_q;
  logic       need_init_q;
  logic       zq_busy_q;
  logic [3:0] imp_code_q;
  logic [3:0] trim_hist_q;
  logic [8:0] fl;
  int         failures;
  int         checks_done;

  assign fl = {pd_q, dpd_q, in_buf_en_q, out_buf_en_q, core_pwr_en_q,
               refresh_en_q, array_valid_q, need_init_q, zq_busy_q};

  lpdpd_power_ctrl lpdpd_power_ctrl_i (
    .clk(clk), .rst_n(rst_n), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca),
    .zq_tied_high(zq_tied_high), .zq_cmd(zq_cmd), .pd_q(pd_q), .dpd_q(dpd_q),
    .in_buf_en_q(in_buf_en_q), .out_buf_en_q(out_buf_en_q),
    .core_pwr_en_q(core_pwr_en_q), .refresh_en_q(refresh_en_q),
    .array_valid_q(array_valid_q), .need_init_q(need_init_q),
    .zq_busy_q(zq_busy_q), .imp_code_q(imp_code_q), .trim_hist_q(trim_hist_q)
  );

  lpdpd_ctrl_model lpdpd_ctrl_model_i (
    .clk(clk), .ck(ck), .cke(cke), .cs_n(cs_n), .ca(ca), .zq_cmd(zq_cmd)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic t_reset();
    check(fl, 9'h07c);
    check(imp_code_q, 4'h8);
    check(trim_hist_q, 4'h8);
    $display("test reset done");
  endtask

  task automatic t_zq();
    lpdpd_ctrl_model_i.frame(1'b1, 1'b1, 4'h7, 1'b1);
    lpdpd_ctrl_model_i.nop(1'b1, 1);
    check({fl, imp_code_q}, {9'h07c, 4'h8});
    @(negedge clk);
    zq_tied_high = 1'b0;
    lpdpd_ctrl_model_i.frame(1'b1, 1'b1, 4'h7, 1'b1);
    check(fl, 9'h07d);
    // 32 ck rises after the command: still busy after 31 of them
    lpdpd_ctrl_model_i.nop(1'b1, 31);
    check(fl, 9'h07d);
    lpdpd_ctrl_model_i.nop(1'b1, 2);
    // result is the old code xor the ca pins seen as calibration ends
    check({fl, imp_code_q}, {9'h07c, 4'hf});
    check(trim_hist_q, 4'hf);
    $display("test zq done");
  endtask

  task automatic t_pd();
    lpdpd_ctrl_model_i.frame(1'b0, 1'b1, 4'h7, 1'b0);
    check(fl, 9'h114);
    lpdpd_ctrl_model_i.nop(1'b0, 2);
    check(fl, 9'h114);
    // stopped link clock in power-down: no rise, so nothing may move
    lpdpd_ctrl_model_i.stall(40);
    check(fl, 9'h114);
    lpdpd_ctrl_model_i.nop(1'b0, 2);
    lpdpd_ctrl_model_i.wake();
    check(fl, 9'h07c);
    $display("test pd done");
  endtask

  task automatic t_dpd();
    // cke low with a nop encoding selected is neither entry
    lpdpd_ctrl_model_i.frame(1'b0, 1'b0, 4'h7, 1'b0);
    lpdpd_ctrl_model_i.nop(1'b1, 1);
    check(fl, 9'h07c);
    lpdpd_ctrl_model_i.frame(1'b0, 1'b0, 4'h3, 1'b0);
    lpdpd_ctrl_model_i.nop(1'b0, 2);
    check(fl, 9'h082);
    lpdpd_ctrl_model_i.wake();
    check({dpd_q, array_valid_q, need_init_q}, 3'b001);
    $display("test dpd done");
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // about 1000 clk of traffic expected; a hang is cut off well after that
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    zq_tied_high = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_zq();
    t_pd();
    t_dpd();
    results();
  end
endmodule
